// [design/sensor_serial_register_access.sv]
// Serial register access for a sensor: SPI framing with 4-bit CRC on the
// link clock, and a supply-line Manchester command receiver with open-drain
// answer. Assumes a register store on clk_i that answers reg_rdata_i in the
// same cycle that reg_addr_o changes, and a comparator level on supply_line_i.
`timescale 1ns/1ps
`include "sensor_link_defs.svh"

module sensor_serial_register_access #(
    parameter int         TW          = 16,
    parameter logic [2:0] CRC3_POLY   = `CRC3_POLY_DEF,
    parameter logic [2:0] CRC3_PRESET = `CRC3_PRESET_DEF
) (
    // Clock and reset
    input  wire logic                     clk_i,
    input  wire logic                     resetn_i,
    // SPI link
    input  wire logic                     spi_sclk_i,
    input  wire logic                     spi_sel_n_i,
    input  wire logic                     spi_mosi_i,
    output logic                          spi_miso_o,
    // Supply line and pulse-width pin
    input  wire logic                     supply_line_i,
    input  wire logic                     pwm_angle_i,
    output logic                          pwm_o,
    output logic                          pwm_oe_o,
    output logic                          man_mode_o,
    // Configuration and status
    input  wire logic                     host_crc_check_enable_i,
    input  wire logic                     supply_line_link_disable_i,
    input  wire logic                     crc_err_clr_i,
    output logic                          crc_err_o,
    output sensor_link_pkg::die_id_t      die_id_o,
    // Register store port
    output logic [5:0]                    reg_addr_o,
    input  wire logic [15:0]              reg_rdata_i,
    output logic                          wr_stb_o,
    output logic [5:0]                    wr_addr_o,
    output logic [15:0]                   wr_data_o,
    output logic [1:0]                    wr_be_o
);
    import sensor_link_pkg::*;

    // Frame CRC over 16 bits, MSB first, shift register preset to ones
    function automatic logic [3:0] crc4(input logic [15:0] d);
        logic [3:0] c;
        logic       fb;
        c = `CRC4_PRESET;
        for (int i = 15; i >= 0; i--) begin
            fb = d[i] ^ c[3];
            c  = {c[2:1], c[0] ^ fb, fb};
        end
        return c;
    endfunction : crc4

    // Supply-line CRC over the n leading bits of an MSB-aligned vector
    function automatic logic [2:0] crc3(input logic [26:0] d, input logic [4:0] n);
        logic [2:0] c;
        logic       fb;
        c = CRC3_PRESET;
        for (int i = 0; i < 27; i++) begin
            if (i < int'(n)) begin
                fb = d[26-i] ^ c[2];
                c  = {c[1:0], 1'b0} ^ (fb ? CRC3_POLY : 3'h0);
            end
        end
        return c;
    endfunction : crc3

    logic [19:0]   rx_sh_reg;
    logic [19:0]   tx_sh_reg;
    logic [19:0]   spi_tx_reg;
    logic          first_reg;
    logic          sclk_s1, sclk_s2, sclk_s3;
    logic          sel_s1, sel_s2, sel_s3;
    logic          mosi_s1, mosi_s2;
    logic          ln_s1, ln_s2, ln_s3;
    logic [4:0]    bit_cnt_reg;
    logic          crc_err_reg;
    logic [5:0]    reg_addr_reg;
    logic          fetch_reg;
    logic          fetch_spi_reg;
    logic          wr_stb_reg;
    logic [5:0]    wr_addr_reg;
    logic [15:0]   wr_data_reg;
    logic [1:0]    wr_be_reg;
    die_id_t       die_id_reg;
    logic          man_mode_reg;
    man_rx_state_t rx_state;
    logic [TW-1:0] rx_t_reg;
    logic [TW-1:0] half_reg;
    logic [31:0]   man_sh_reg;
    logic [5:0]    man_n_reg;
    logic          man_done_reg;
    logic [22:0]   mtx_sh_reg;
    logic [4:0]    mtx_n_reg;
    logic          mtx_half_reg;
    logic [TW-1:0] mtx_t_reg;
    logic          mtx_busy_reg;
    logic          pwm_oe_reg;

    // Link clock domain: MOSI sampled on rising edges
    always_ff @(posedge spi_sclk_i) begin
        rx_sh_reg <= {rx_sh_reg[18:0], spi_mosi_i};
    end

    // Link clock domain: MISO changes on falling edges; first_reg is stable
    // across the first edge and settles well inside half a link period
    always_ff @(negedge spi_sclk_i) begin
        if (!resetn_i) begin
            spi_miso_o <= 1'b0;
            tx_sh_reg  <= 20'h00000;
        end else if (first_reg) begin
            spi_miso_o <= spi_tx_reg[19];
            tx_sh_reg  <= {spi_tx_reg[18:0], 1'b0};
        end else begin
            spi_miso_o <= tx_sh_reg[19];
            tx_sh_reg  <= {tx_sh_reg[18:0], 1'b0};
        end
    end

    // Synchronisers for pins and the link clock seen from clk_i
    always_ff @(posedge clk_i) begin
        sclk_s1 <= spi_sclk_i;
        sclk_s2 <= sclk_s1;
        sclk_s3 <= sclk_s2;
        sel_s1  <= spi_sel_n_i;
        sel_s2  <= sel_s1;
        sel_s3  <= sel_s2;
        mosi_s1 <= spi_mosi_i;
        mosi_s2 <= mosi_s1;
        ln_s1   <= supply_line_i;
        ln_s2   <= ln_s1;
        ln_s3   <= ln_s2;
    end

    // SPI frame decode at deselect; the shift register is idle by then
    logic        spi_end;
    logic        len_ok;
    logic        len_crc;
    logic [15:0] spi_pay;
    logic        crc_bad;
    logic        spi_ok;
    always_comb begin
        spi_end = sel_s2 & ~sel_s3;
        len_crc = (bit_cnt_reg == `SPI_CRC_FRAME);
        len_ok  = len_crc | (bit_cnt_reg == `SPI_CMD_BITS);
        spi_pay = len_crc ? rx_sh_reg[19:4] : rx_sh_reg[15:0];
        crc_bad = len_crc & host_crc_check_enable_i
                  & (rx_sh_reg[3:0] != crc4(rx_sh_reg[19:4]));
        spi_ok  = spi_end & len_ok & ~crc_bad & ~spi_pay[`SPI_LEAD_BIT];
    end

    // Rising link edges in the frame; first_reg marks the first bit slot
    always_ff @(posedge clk_i) begin
        if (!resetn_i || sel_s2) begin
            bit_cnt_reg <= 5'd0;
            first_reg   <= 1'b1;
        end else begin
            if (sclk_s2 && !sclk_s3 && bit_cnt_reg != 5'h1f) begin
                bit_cnt_reg <= bit_cnt_reg + 5'd1;
            end
            first_reg <= (bit_cnt_reg == 5'd0) && !(sclk_s2 && !sclk_s3);
        end
    end

    // Sticky CRC error flag; a new error wins over the clear
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            crc_err_reg <= 1'b0;
        end else if (spi_end && len_ok && crc_bad) begin
            crc_err_reg <= 1'b1;
        end else if (crc_err_clr_i) begin
            crc_err_reg <= 1'b0;
        end
    end

    // Die ID straps followed while the angle output is in use
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            die_id_reg <= 2'd0;
        end else if (!man_mode_reg) begin
            die_id_reg <= {mosi_s2, sel_s2};
        end
    end

    // Supply-line receiver: half bit measured from the first sync bit,
    // boundary edges blanked, a silence of three half bits ends the frame
    logic          ln_edge;
    logic [TW+1:0] blank;
    logic [TW+1:0] tmo;
    always_comb begin
        ln_edge = ln_s2 ^ ln_s3;
        blank   = {2'b00, half_reg} + {3'b000, half_reg[TW-1:1]};
        tmo     = {2'b00, half_reg} + {1'b0, half_reg, 1'b0};
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i || supply_line_link_disable_i) begin
            rx_state     <= RX_IDLE;
            rx_t_reg     <= '0;
            half_reg     <= '0;
            man_sh_reg   <= 32'h00000000;
            man_n_reg    <= 6'd0;
            man_done_reg <= 1'b0;
        end else begin
            man_done_reg <= 1'b0;
            case (rx_state)
                RX_IDLE: begin
                    rx_t_reg <= '0;
                    if (ln_edge && !ln_s2) begin
                        rx_state <= RX_HALF;
                    end
                end
                RX_HALF: begin
                    rx_t_reg <= rx_t_reg + 1'b1;
                    if (ln_edge) begin
                        half_reg   <= rx_t_reg + 1'b1;
                        rx_t_reg   <= '0;
                        man_sh_reg <= 32'h00000000;
                        man_n_reg  <= 6'd1;
                        rx_state   <= RX_BITS;
                    end else if (&rx_t_reg) begin
                        rx_state <= RX_IDLE;
                    end
                end
                RX_BITS: begin
                    rx_t_reg <= rx_t_reg + 1'b1;
                    if (ln_edge && {2'b00, rx_t_reg} >= blank) begin
                        man_sh_reg <= {man_sh_reg[30:0], ln_s3};
                        man_n_reg  <= (man_n_reg == 6'h3f) ? man_n_reg : man_n_reg + 6'd1;
                        rx_t_reg   <= '0;
                    end else if ({2'b00, rx_t_reg} >= tmo || &rx_t_reg) begin
                        man_done_reg <= 1'b1;
                        rx_state     <= RX_IDLE;
                    end
                end
                default: rx_state <= RX_IDLE;
            endcase
        end
    end

    // Supply-line command decode; bit 0 of the shift register is the last bit
    logic        m_rd;
    logic        m_wr;
    logic        m_sel;
    logic        m_access;
    logic        m_exit;
    logic [3:0]  m_tgt;
    logic [5:0]  m_addr;
    always_comb begin
        m_rd   = man_done_reg && man_n_reg == `MAN_RD_BITS && man_sh_reg[15:14] == 2'b00
                 && man_sh_reg[13]
                 && man_sh_reg[2:0] == crc3({man_sh_reg[13:3], 16'h0000}, `MAN_RD_CRC_BITS);
        m_wr   = man_done_reg && man_n_reg == `MAN_WR_BITS && man_sh_reg[31:30] == 2'b00
                 && !man_sh_reg[29]
                 && man_sh_reg[2:0] == crc3(man_sh_reg[29:3], `MAN_WR_CRC_BITS);
        m_tgt  = m_rd ? man_sh_reg[12:9] : man_sh_reg[28:25];
        m_addr = m_rd ? man_sh_reg[8:3] : man_sh_reg[24:19];
        m_sel  = (m_tgt == 4'h0) || m_tgt[die_id_reg];
        m_access = m_wr && man_sh_reg[24:19] == `MAN_ACCESS_ADDR
                   && man_sh_reg[18:3] == `MAN_ACCESS_DATA;
        m_exit   = m_wr && man_sh_reg[24:19] == `MAN_ACCESS_ADDR && !m_access;
    end

    // Mode: entered by the access code, left by the exit code
    always_ff @(posedge clk_i) begin
        if (!resetn_i || supply_line_link_disable_i) begin
            man_mode_reg <= 1'b0;
        end else if (m_access) begin
            man_mode_reg <= 1'b1;
        end else if (m_exit && man_mode_reg) begin
            man_mode_reg <= 1'b0;
        end
    end

    // Register reads: SPI reads win; a Manchester read in the same cycle
    // is lost
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            reg_addr_reg  <= 6'h00;
            fetch_reg     <= 1'b0;
            fetch_spi_reg <= 1'b0;
        end else begin
            fetch_reg <= 1'b0;
            if (spi_ok && !spi_pay[`SPI_RW_BIT]) begin
                reg_addr_reg  <= spi_pay[`SPI_ADDR_HI:`SPI_ADDR_LO];
                fetch_reg     <= 1'b1;
                fetch_spi_reg <= 1'b1;
            end else if (m_rd && man_mode_reg && m_sel && !mtx_busy_reg) begin
                reg_addr_reg  <= m_addr;
                fetch_reg     <= 1'b1;
                fetch_spi_reg <= 1'b0;
            end
        end
    end

    // Answer word: full pair, odd byte only, or zero for address zero
    logic [15:0] resp;
    always_comb begin
        if (reg_addr_reg == `SPI_ZERO_ADDR) begin
            resp = 16'h0000;
        end else if (reg_addr_reg[0]) begin
            resp = {8'h00, reg_rdata_i[7:0]};
        end else begin
            resp = reg_rdata_i;
        end
    end

    // SPI answer word for the next frame; cleared by frames without a read
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            spi_tx_reg <= 20'h00000;
        end else if (fetch_reg && fetch_spi_reg) begin
            spi_tx_reg <= {resp, crc4(resp)};
        end else if (spi_end) begin
            spi_tx_reg <= 20'h00000;
        end
    end

    // Register writes from SPI bytes and selected Manchester words
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            wr_stb_reg  <= 1'b0;
            wr_addr_reg <= 6'h00;
            wr_data_reg <= 16'h0000;
            wr_be_reg   <= 2'b00;
        end else begin
            wr_stb_reg <= 1'b0;
            if (spi_ok && spi_pay[`SPI_RW_BIT]) begin
                wr_stb_reg  <= 1'b1;
                wr_addr_reg <= spi_pay[`SPI_ADDR_HI:`SPI_ADDR_LO];
                wr_data_reg <= {spi_pay[7:0], spi_pay[7:0]};
                wr_be_reg   <= spi_pay[`SPI_ADDR_LO] ? 2'b01 : 2'b10;
            end else if (m_wr && man_mode_reg && m_sel && m_addr != `MAN_ACCESS_ADDR) begin
                wr_stb_reg  <= 1'b1;
                wr_addr_reg <= m_addr;
                wr_data_reg <= man_sh_reg[18:3];
                wr_be_reg   <= 2'b11;
            end
        end
    end

    // Manchester answer: sync, die ID, data, CRC at the measured rate
    always_ff @(posedge clk_i) begin
        if (!resetn_i || !man_mode_reg) begin
            mtx_busy_reg <= 1'b0;
            mtx_sh_reg   <= 23'h000000;
            mtx_n_reg    <= 5'd0;
            mtx_half_reg <= 1'b0;
            mtx_t_reg    <= '0;
        end else if (fetch_reg && !fetch_spi_reg) begin
            mtx_busy_reg <= 1'b1;
            mtx_sh_reg   <= {2'b00, die_id_reg, resp,
                             crc3({die_id_reg, resp, 9'h000}, `MAN_RSP_CRC_BITS)};
            mtx_n_reg    <= `MAN_RSP_BITS;
            mtx_half_reg <= 1'b0;
            mtx_t_reg    <= '0;
        end else if (mtx_busy_reg) begin
            mtx_t_reg <= mtx_t_reg + 1'b1;
            if (mtx_t_reg + 1'b1 >= half_reg) begin
                mtx_t_reg    <= '0;
                mtx_half_reg <= ~mtx_half_reg;
                if (mtx_half_reg) begin
                    mtx_sh_reg <= {mtx_sh_reg[21:0], 1'b0};
                    mtx_n_reg  <= mtx_n_reg - 5'd1;
                    if (mtx_n_reg == 5'd1) begin
                        mtx_busy_reg <= 1'b0;
                    end
                end
            end
        end
    end

    // Open-drain pin: answer bits, silence in mode, else angle waveform;
    // a one is high then low, a zero low then high
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            pwm_oe_reg <= 1'b0;
        end else if (mtx_busy_reg) begin
            pwm_oe_reg <= ~(mtx_sh_reg[22] ^ mtx_half_reg);
        end else if (man_mode_reg) begin
            pwm_oe_reg <= 1'b0;
        end else begin
            pwm_oe_reg <= ~pwm_angle_i;
        end
    end

    // Output drivers from flops
    always_ff @(posedge clk_i) begin
        pwm_o <= 1'b0;
    end
    assign pwm_oe_o   = pwm_oe_reg;
    assign man_mode_o = man_mode_reg;
    assign crc_err_o  = crc_err_reg;
    assign die_id_o   = die_id_reg;
    assign reg_addr_o = reg_addr_reg;
    assign wr_stb_o   = wr_stb_reg;
    assign wr_addr_o  = wr_addr_reg;
    assign wr_data_o  = wr_data_reg;
    assign wr_be_o    = wr_be_reg;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    a_odd_upper_zero: assert property (fetch_reg && fetch_spi_reg && reg_addr_reg[0]
        |=> spi_tx_reg[19:12] == 8'h00) else $error("odd read upper byte not zero");
    a_even_full_word: assert property (fetch_reg && fetch_spi_reg && !reg_addr_reg[0]
        && reg_addr_reg != 6'h00 |=> spi_tx_reg[19:4] == $past(reg_rdata_i))
        else $error("even read word mismatch");
    a_zero_addr_word: assert property (fetch_reg && fetch_spi_reg && reg_addr_reg == 6'h00
        |=> spi_tx_reg == 20'h0000d) else $error("address zero answer wrong");
    a_crc_appended: assert property (fetch_reg && fetch_spi_reg
        |=> spi_tx_reg[3:0] == crc4(spi_tx_reg[19:4])) else $error("MISO CRC wrong");
    a_crc_drop_flag: assert property (spi_end && len_crc && crc_bad
        |=> crc_err_reg && !wr_stb_reg && !fetch_reg) else $error("bad CRC packet used");
    a_crc_err_sticky: assert property (crc_err_reg && !crc_err_clr_i
        |=> crc_err_reg) else $error("CRC flag lost");
    a_disable_no_mode: assert property (supply_line_link_disable_i
        |=> !man_mode_reg && rx_state == RX_IDLE) else $error("link disable ignored");
    a_mode_stops_pwm: assert property ($rose(man_mode_reg) && !mtx_busy_reg
        |=> !pwm_oe_reg) else $error("angle output not stopped");
    a_answer_needs_mode: assert property (mtx_busy_reg |-> man_mode_reg)
        else $error("answer outside mode");
    a_write_one_pulse: assert property (wr_stb_reg |=> !wr_stb_reg ##1 !wr_stb_reg
        or !wr_stb_reg) else $error("write strobe too long");

endmodule : sensor_serial_register_access

// [design/sensor_link_defs.svh]
// Constants for the sensor serial register access block: frame layouts,
// fixed codes and CRC presets. Definitions only; included by bare name.
`ifndef SENSOR_LINK_DEFS_SVH
`define SENSOR_LINK_DEFS_SVH

// SPI frame lengths and command field positions
`define SPI_CMD_BITS      5'd16
`define SPI_CRC_FRAME     5'd20
`define SPI_LEAD_BIT      15
`define SPI_RW_BIT        14
`define SPI_ADDR_HI       13
`define SPI_ADDR_LO       8
`define SPI_ZERO_ADDR     6'h00
`define CRC4_PRESET       4'hf

// Supply-line frame lengths and fixed codes
`define MAN_RD_BITS       6'd16
`define MAN_WR_BITS       6'd32
`define MAN_RSP_BITS      5'd23
`define MAN_RD_CRC_BITS   5'd11
`define MAN_WR_CRC_BITS   5'd27
`define MAN_RSP_CRC_BITS  5'd18
`define MAN_ACCESS_ADDR   6'h3f
`define MAN_ACCESS_DATA   16'h62d2
`define CRC3_POLY_DEF     3'h3
`define CRC3_PRESET_DEF   3'h7

`endif

// [design/sensor_link_pkg.sv]
// Types shared by the sensor serial register access block.
// Assumes nothing of its surroundings.
package sensor_link_pkg;
    typedef logic [1:0] die_id_t;
    typedef enum logic [1:0] {RX_IDLE, RX_HALF, RX_BITS} man_rx_state_t;
endpackage : sensor_link_pkg

// [tb/host_ctrl_model.sv]
// Host controller model: SPI mode 3 master and supply-line Manchester sender.
// Assumes the device samples MOSI on SCLK rising and the supply line idles high.
`timescale 1ns/1ps

module host_ctrl_model (
    // SPI side
    output logic      sclk_o,
    output logic      sel_n_o,
    output logic      mosi_o,
    input  wire logic miso_i,
    // Supply line
    output logic      line_o
);
    // Idle levels: clock high, deselected, line high
    initial begin
        sclk_o = 1'b1;
        sel_n_o = 1'b1;
        mosi_o = 1'b0;
        line_o = 1'b1;
    end

    // One SPI frame; the clock stands high outside it
    task automatic xfer(input logic [19:0] tx, input int n, output logic [19:0] rx);
        rx = '0;
        sel_n_o = 1'b0;
        #53;
        for (int i = n - 1; i >= 0; i--) begin
            sclk_o = 1'b0;
            mosi_o = tx[i];
            #40;
            sclk_o = 1'b1;
            rx[i] = miso_i;
            #40;
        end
        sel_n_o = 1'b1;
        mosi_o = 1'b0;
        #200;
    endtask : xfer

    // Manchester frame, first half carries the bit, so a 1 falls mid-bit
    task automatic man_send(input logic [31:0] fr, input int n, input int h);
        for (int i = n - 1; i >= 0; i--) begin
            line_o = fr[i];
            #(h * 8);
            line_o = ~fr[i];
            #(h * 8);
        end
        line_o = 1'b1;
        #(h * 8);
    endtask : man_send
endmodule : host_ctrl_model

// [tb/sensor_serial_register_access_tb.sv]
// Self-checking bench for the serial register access block.
// Assumes the host model is compiled first and the design store is modelled here.
`timescale 1ns/1ps
`include "sensor_link_defs.svh"

module sensor_serial_register_access_tb;
    logic        clk_i = 1'b0;
    logic        resetn_i = 1'b0;
    logic        sclk, sel_n, mosi, miso, line, pwm, pwm_oe, man_mode, crc_err, wr_stb;
    logic        pwm_angle_i = 1'b1;
    logic        ang_rand = 1'b1;
    logic        ang_lvl = 1'b1;
    logic        crc_en = 1'b0;
    logic        link_dis = 1'b0;
    logic        err_clr = 1'b0;
    sensor_link_pkg::die_id_t die_id;
    logic [5:0]  reg_addr, wr_addr;
    logic [15:0] wr_data, rdata;
    logic [1:0]  wr_be;
    logic [23:0] wq[$];
    logic [31:0] seed = 32'd2213;
    int          n_errors = 0;
    int          tests_run = 0;
    int          cyc = 0;

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    function automatic logic [15:0] word_of(logic [5:0] a);
        return {2'b11, a[5:1], 1'b0, 2'b01, a[5:1], 1'b0};
    endfunction : word_of

    // Expected answer word: zero for address zero, odd byte alone, else the pair
    function automatic logic [15:0] exp_word(logic [5:0] a);
        logic [15:0] v;
        v = word_of(a);
        if (a == 6'h00) v = 16'h0000;
        else if (a[0]) v = {8'h00, v[7:0]};
        return v;
    endfunction : exp_word

    function automatic logic [3:0] crc4(logic [15:0] d);
        logic [3:0] c = 4'hf;
        for (int i = 15; i >= 0; i--) begin
            c = {c[2], c[1], c[0] ^ d[i] ^ c[3], d[i] ^ c[3]};
        end
        return c;
    endfunction : crc4

    function automatic logic [2:0] crc3(logic [26:0] d, int n);
        logic [2:0] c = `CRC3_PRESET_DEF;
        for (int i = n - 1; i >= 0; i--) begin
            c = {c[1], c[0] ^ d[i] ^ c[2], d[i] ^ c[2]};
        end
        return c;
    endfunction : crc3

    // Clock and combinational register store
    always #4 clk_i = ~clk_i;
    assign rdata = word_of(reg_addr);

    sensor_serial_register_access #(.TW(16)) sensor_serial_register_access_inst (
        .clk_i(clk_i), .resetn_i(resetn_i), .spi_sclk_i(sclk), .spi_sel_n_i(sel_n),
        .spi_mosi_i(mosi), .spi_miso_o(miso), .supply_line_i(line),
        .pwm_angle_i(pwm_angle_i), .pwm_o(pwm), .pwm_oe_o(pwm_oe), .man_mode_o(man_mode),
        .host_crc_check_enable_i(crc_en), .supply_line_link_disable_i(link_dis),
        .crc_err_clr_i(err_clr), .crc_err_o(crc_err), .die_id_o(die_id),
        .reg_addr_o(reg_addr), .reg_rdata_i(rdata), .wr_stb_o(wr_stb),
        .wr_addr_o(wr_addr), .wr_data_o(wr_data), .wr_be_o(wr_be));

    host_ctrl_model host_ctrl_model_inst (
        .sclk_o(sclk), .sel_n_o(sel_n), .mosi_o(mosi), .miso_i(miso), .line_o(line));

    task automatic summarize();
        $display("Comparisons %0d, errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : summarize

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    task automatic spi_wr(input logic [5:0] a, input logic [7:0] d, input logic [3:0] cx,
                          input logic ok, input int n);
        logic [19:0] rx;
        if (ok) wq.push_back({a, d, d, a[0] ? 2'b01 : 2'b10});
        if (n == 20) host_ctrl_model_inst.xfer({2'b01, a, d, crc4({2'b01, a, d}) ^ cx}, 20, rx);
        else host_ctrl_model_inst.xfer({4'h0, 2'b01, a, d}, 16, rx);
    endtask : spi_wr

    task automatic man_cmd(input logic rd, input logic [3:0] t, input logic [5:0] a,
                           input logic [15:0] d, input int h, input logic want);
        logic [26:0] b;
        logic        seen;
        logic [22:0] ans;
        logic [15:0] v;
        b = rd ? {16'h0, 1'b1, t, a} : {1'b0, t, a, d};
        seen = 1'b0;
        ans = '0;
        v = exp_word(a);
        if (rd) host_ctrl_model_inst.man_send({16'h0, 2'b00, b[10:0], crc3(b, 11)}, 16, h);
        else host_ctrl_model_inst.man_send({2'b00, b, crc3(b, 27)}, 32, h);
        repeat (300) begin
            @(negedge clk_i);
            if (!seen && pwm_oe === 1'b1) begin
                seen = 1'b1;
                // Sample the first half of each answer bit; a low pin there is a zero
                repeat (h / 2) @(negedge clk_i);
                for (int k = 0; k < 23; k++) begin
                    ans = {ans[21:0], ~pwm_oe};
                    repeat (2 * h) @(negedge clk_i);
                end
            end
        end
        check(seen, want, "answer");
        if (want) check(ans, {4'b0001, v, crc3({11'h001, v}, 18)}, "answer word");
        repeat (1000) @(negedge clk_i);
    endtask : man_cmd

    // Random angle waveform early on; each write strobe takes the oldest note
    always @(negedge clk_i) pwm_angle_i <= ang_rand ? ^rnd() : ang_lvl;
    always @(negedge clk_i) begin
        cyc++;
        if (wr_stb === 1'b1) begin
            if (wq.size() == 0) check({wr_addr, wr_data, wr_be}, 24'hffffff, "stray write");
            else check({wr_addr, wr_data, wr_be}, wq.pop_front(), "write");
        end
        if (cyc == 60000) begin
            n_errors++;
            summarize();
        end
    end

    // Main sequence
    initial begin
        logic [19:0] rx;
        logic [15:0] w;
        logic [5:0]  rd[5];
        logic [15:0] e;
        repeat (5) @(negedge clk_i);
        resetn_i = 1'b1;
        repeat (5) @(negedge clk_i);
        check(die_id, 2'b01, "die id");
        for (int k = 0; k < 4; k++) begin
            w = 16'(rnd());
            spi_wr(w[13:8], w[7:0], 4'h0, 1'b1, k[0] ? 20 : 16);
        end
        w = 16'(rnd());
        rd = '{6'h24, 6'h25, w[5:0] & 6'h3e, 6'h00, 6'h00};
        for (int i = 0; i < 5; i++) begin
            host_ctrl_model_inst.xfer({2'b00, rd[i], 8'h00, crc4({2'b00, rd[i], 8'h00})}, 20, rx);
            if (i > 0) begin
                e = exp_word(rd[i - 1]);
                check(rx, {e, crc4(e)}, "read");
            end
        end
        ang_rand = 1'b0;
        crc_en = 1'b1;
        spi_wr(6'h11, 8'ha5, 4'h6, 1'b0, 20);
        check(crc_err, 1'b1, "crc flag");
        @(negedge clk_i);
        err_clr = 1'b1;
        @(negedge clk_i);
        err_clr = 1'b0;
        repeat (2) @(negedge clk_i);
        check(crc_err, 1'b0, "crc clear");
        spi_wr(6'h12, 8'h3c, 4'h0, 1'b1, 20);
        crc_en = 1'b0;
        spi_wr(6'h13, 8'hc3, 4'h9, 1'b1, 20);
        ang_lvl = 1'b1;
        link_dis = 1'b1;
        man_cmd(1'b0, 4'h0, `MAN_ACCESS_ADDR, `MAN_ACCESS_DATA, 16, 1'b0);
        check(man_mode, 1'b0, "disabled");
        link_dis = 1'b0;
        man_cmd(1'b1, 4'h2, 6'h24, 16'h0, 16, 1'b0);
        man_cmd(1'b0, 4'h4, `MAN_ACCESS_ADDR, `MAN_ACCESS_DATA, 24, 1'b0);
        check(man_mode, 1'b1, "mode entry");
        ang_lvl = 1'b0;
        repeat (4) @(negedge clk_i);
        check(pwm_oe, 1'b0, "angle stopped");
        check(pwm, 1'b0, "open drain level");
        ang_lvl = 1'b1;
        man_cmd(1'b1, 4'h2, 6'h24, 16'h0, 24, 1'b1);
        man_cmd(1'b1, 4'h5, 6'h24, 16'h0, 16, 1'b0);
        man_cmd(1'b1, 4'h0, 6'h25, 16'h0, 16, 1'b1);
        wq.push_back({6'h12, w, 2'b11});
        man_cmd(1'b0, 4'h2, 6'h12, w, 16, 1'b0);
        man_cmd(1'b0, 4'h1, `MAN_ACCESS_ADDR, 16'h0000, 16, 1'b0);
        check(man_mode, 1'b0, "mode exit");
        check(wq.size(), 0, "writes left");
        summarize();
    end
endmodule : sensor_serial_register_access_tb
